// ===== src/tx_symbol_encoder.sv
// transmit coder: nibbles to 4b/5b, scrambled, nrzi and three-level drive
`timescale 1ns/1ps

// Functional notes
// - every 4-bit nibble in a frame becomes a 5-bit code-group before serialisation
// - first preamble octet of a frame is replaced by 11000 then 10001
// - later preamble and data nibbles are each coded to their code-group
// - on transmit enable falling, append 01101 then 00111
// - after the end pair, send idle until transmit enable returns
// - scrambler is a free-running closed-loop 11-bit LFSR
// - each serial NRZ bit is XORed with the scrambler output bit
// - scrambler seed derives from the five address strap inputs
// - a bypass setting passes code-groups on without scrambling
// - scrambled stream is NRZI coded, toggling on each one bit
// - NRZI stream splits into two drives with alternating one-events
// - only three-level coding goes to the line, no binary mode
// - halt is an error; idle, start and end codes carry fixed nibbles
// - control codes inside the data field read as invalid with error
// - transmit sequencing follows the standard fast ethernet machine
// - unscrambled idle is five consecutive one bits
module tx_symbol_encoder #(
    parameter int NW = tx_coder_pkg::NIB_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // nibble stream from the MAC
    input wire logic nib_valid,
    input wire logic tx_enable,
    input wire logic [NW-1:0] tx_nibble,
    output logic nib_ready,
    // configuration
    input wire logic [tx_coder_pkg::STRAP_W-1:0] phy_address_strap,
    input wire logic scramble_bypass,
    // line drive pair
    output logic line_drive_p,
    output logic line_drive_n,
    // status of the code-group on the wire
    output logic frame_active,
    output logic [NW-1:0] sent_nibble,
    output logic sent_error
);
    import tx_coder_pkg::*;

    // =========================================================
    // input buffer

    // words arrive at any clock but leave only
    // at group boundaries, one every five clocks;
    // two entries cover the lag of one group, so a
    // back-to-back source never loses a nibble
    nib_if #(.W(NW)) nib ();

    // a stall by the encoder holds words here; ready back-pressures the MAC
    nib_buffer #(.W(NW)) u_buffer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_valid(nib_valid),
        .in_en(tx_enable),
        .in_data(tx_nibble),
        .in_ready(nib_ready),
        .q(nib)
    );

    // =========================================================
    // state

    tx_state_t state_reg;
    tx_state_t state_next;
    logic [2:0] bit_cnt_reg;
    logic [CG_W-1:0] shift_reg;
    logic [CG_W-1:0] code_next;
    logic pop;
    logic [LFSR_W-1:0] lfsr_reg;
    logic seed_done_reg;
    logic scr_bit_reg;
    logic nrzi_reg;
    logic [1:0] mlt_phase_reg;
    logic drive_p_reg;
    logic drive_n_reg;
    logic active_reg;
    logic [NW-1:0] sent_nibble_reg;
    logic sent_error_reg;

    // =========================================================
    // code-group boundary decode

    // bit counter runs 0..4; the edge that sees 4
    // both sends the last bit and loads the next
    // group, so the line never shows a gap
    // a new code-group is loaded once the last of five bits has gone
    wire boundary = (bit_cnt_reg == CG_LAST);
    wire word_in = nib.valid;
    wire word_en = nib.en;
    wire frame_word = word_in & word_en;
    wire stop_word = word_in & ~word_en;
    wire [CG_W-1:0] data_code = DATA_CG[nib.data];

    // =========================================================
    // frame sequencing

    // a frame is the run of words with enable high;
    // the first two are eaten by the start pair,
    // the first enable-low word closes the frame
    // and its nibble is thrown away
    // limitation: a frame of one word sends the
    // first start group then the end pair, no second
    // the buffer is drained only at code-group boundaries
    assign nib.ready = pop;

    // next code-group and state, chosen once per five bit times
    always_comb
    begin
        state_next = state_reg;
        code_next = CG_IDLE;
        pop = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                code_next = CG_IDLE;
                if (frame_word)
                begin
                    // first preamble nibble is swallowed by the start pair
                    code_next = CG_SSD1;
                    state_next = ST_SSD2;
                    pop = boundary;
                end
                else if (stop_word)
                begin
                    // stray words with enable low between frames are dropped
                    pop = boundary;
                end
            end
            ST_SSD2:
            begin
                // underrun mid-frame shows as halt; the slot is retried
                code_next = CG_HALT;
                if (frame_word)
                begin
                    code_next = CG_SSD2;
                    state_next = ST_DATA;
                    pop = boundary;
                end
                else if (stop_word)
                begin
                    code_next = CG_ESD1;
                    state_next = ST_ESD2;
                    pop = boundary;
                end
            end
            ST_DATA:
            begin
                code_next = CG_HALT;
                if (frame_word)
                begin
                    code_next = data_code;
                    pop = boundary;
                end
                else if (stop_word)
                begin
                    // enable falling closes the frame with the end pair
                    code_next = CG_ESD1;
                    state_next = ST_ESD2;
                    pop = boundary;
                end
            end
            ST_ESD2:
            begin
                code_next = CG_ESD2;
                state_next = ST_IDLE;
            end
            default:
            begin
                code_next = CG_IDLE;
                state_next = ST_IDLE;
            end
        endcase
    end

    // state only moves at a boundary, so a frame decision spans a group
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= ST_IDLE;
            active_reg <= 1'b0;
        end
        else if (boundary)
        begin
            state_reg <= state_next;
            active_reg <= (state_next != ST_IDLE);
        end
    end

    // =========================================================
    // serialiser

    // serial rate equals the clock rate here,
    // above the nominal line rate; only the ratio
    // of five bits per nibble matters to the logic
    // msb leaves first; reset loads idle so the line starts in ones
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_cnt_reg <= CG_FIRST;
            shift_reg <= CG_IDLE;
        end
        else if (boundary)
        begin
            bit_cnt_reg <= CG_FIRST;
            shift_reg <= code_next;
        end
        else
        begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= {shift_reg[CG_W-2:0], 1'b0};
        end
    end

    wire nrz_bit = shift_reg[CG_W-1];

    // =========================================================
    // scrambler

    // the mask is the feedback bit itself, so a
    // receiver that learns eleven mask bits from
    // idle can run its own copy in step
    // the register keeps running in bypass, so
    // leaving bypass needs no resynchronising
    // feedback of the closed loop; this bit also masks the data
    wire lfsr_fb = lfsr_reg[LFSR_TAP_A] ^ lfsr_reg[LFSR_TAP_B];
    // seed always has its top bit set, so the register never locks at zero
    wire [LFSR_W-1:0] seed = {SEED_HI, phy_address_strap};
    wire scr_next = scramble_bypass ? nrz_bit : (nrz_bit ^ lfsr_fb);

    // the strap is caught on the first edge after reset, not under reset
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lfsr_reg <= LFSR_RST;
            seed_done_reg <= 1'b0;
        end
        else if (!seed_done_reg)
        begin
            lfsr_reg <= seed;
            seed_done_reg <= 1'b1;
        end
        else
        begin
            lfsr_reg <= {lfsr_reg[LFSR_W-2:0], lfsr_fb};
        end
    end

    // masked bit, or the plain code bit when bypassed
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            scr_bit_reg <= 1'b0;
        end
        else
        begin
            scr_bit_reg <= scr_next;
        end
    end

    // =========================================================
    // nrzi and three-level drive

    // two clocks from code bit to drive: one in the
    // masking flop, one in the nrzi and phase flops
    // the phase wraps 0, +, 0, -; a one bit steps
    // it, a zero bit holds the level
    wire nrzi_next = nrzi_reg ^ scr_bit_reg;
    // each nrzi transition steps the level through 0, +, 0, -
    wire mlt_step = (nrzi_next != nrzi_reg);
    wire [1:0] mlt_next = mlt_phase_reg + {1'b0, mlt_step};

    // the pair is only ever driven three-level; there is no binary path
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            nrzi_reg <= 1'b0;
            mlt_phase_reg <= MLT_ZERO;
            drive_p_reg <= 1'b0;
            drive_n_reg <= 1'b0;
        end
        else
        begin
            nrzi_reg <= nrzi_next;
            mlt_phase_reg <= mlt_next;
            drive_p_reg <= (mlt_next == MLT_POS);
            drive_n_reg <= (mlt_next == MLT_NEG);
        end
    end

    // =========================================================
    // code-group monitor

    // decodes the group just loaded, as a receiver
    // would, so the status shows what went out
    // rather than what the mac offered
    // halt only appears on an underrun; a data slot
    // never carries a control group in normal use
    // a control code standing in a data slot is flagged as invalid
    cg_view_t view;
    assign view = cg_decode(code_next);
    wire in_data_slot = (state_reg == ST_DATA) & frame_word;
    wire slot_error = view.invalid | (view.control & in_data_slot);
    wire [NW-1:0] slot_nibble = slot_error ? NIB_BAD : view.nibble;

    // updated with each loaded code-group, held for its five bit times
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sent_nibble_reg <= NIB_IDLE;
            sent_error_reg <= 1'b0;
        end
        else if (boundary)
        begin
            sent_nibble_reg <= slot_nibble;
            sent_error_reg <= slot_error;
        end
    end

    // =========================================================
    // outputs

    // every output is a flop; no decode sits
    // between a register and a pin
    assign line_drive_p = drive_p_reg;
    assign line_drive_n = drive_n_reg;
    assign frame_active = active_reg;
    assign sent_nibble = sent_nibble_reg;
    assign sent_error = sent_error_reg;

endmodule : tx_symbol_encoder

// ===== src/tx_coder_pkg.sv
// constants, code-groups and helpers for the transmit symbol coder
package tx_coder_pkg;

    // =========================================================
    // widths and counts
    localparam int NIB_W = 4;
    localparam int CG_W = 5;
    localparam int STRAP_W = 5;
    localparam int LFSR_W = 11;
    localparam int BUF_DEPTH = 2;
    localparam logic [2:0] CG_LAST = 3'h4;
    localparam logic [2:0] CG_FIRST = 3'h0;

    // =========================================================
    // scrambler: x^11 + x^9 + 1, taps at bit 10 and bit 8
    localparam int LFSR_TAP_A = 10;
    localparam int LFSR_TAP_B = 8;
    localparam logic [LFSR_W-1:0] LFSR_RST = 11'h7FF;
    localparam logic [5:0] SEED_HI = 6'h20;

    // =========================================================
    // line coding phases of the three-level signal
    localparam logic [1:0] MLT_ZERO = 2'h0;
    localparam logic [1:0] MLT_POS = 2'h1;
    localparam logic [1:0] MLT_NEG = 2'h3;

    // =========================================================
    // control code-groups and their nibble meanings
    localparam logic [CG_W-1:0] CG_IDLE = 5'h1F;
    localparam logic [CG_W-1:0] CG_SSD1 = 5'h18;
    localparam logic [CG_W-1:0] CG_SSD2 = 5'h11;
    localparam logic [CG_W-1:0] CG_ESD1 = 5'h0D;
    localparam logic [CG_W-1:0] CG_ESD2 = 5'h07;
    localparam logic [CG_W-1:0] CG_HALT = 5'h04;
    localparam logic [NIB_W-1:0] NIB_IDLE = 4'h0;
    localparam logic [NIB_W-1:0] NIB_SSD = 4'h5;
    localparam logic [NIB_W-1:0] NIB_ESD = 4'h0;
    localparam logic [NIB_W-1:0] NIB_BAD = 4'hE;

    // data code-groups for nibbles 0..F
    localparam logic [CG_W-1:0] DATA_CG [16] = '{
        5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

    typedef enum logic [1:0] {ST_IDLE, ST_SSD2, ST_DATA, ST_ESD2} tx_state_t;

    // decoded view of a code-group: {invalid, control, nibble}
    typedef struct packed {
        logic invalid;
        logic control;
        logic [NIB_W-1:0] nibble;
    } cg_view_t;

    function automatic cg_view_t cg_decode(input logic [CG_W-1:0] cg);
        cg_view_t v;
        v = '{invalid: 1'b1, control: 1'b0, nibble: NIB_BAD};
        for (int i = 0; i < 16; i++)
        begin
            if (DATA_CG[i] == cg)
            begin
                v = '{invalid: 1'b0, control: 1'b0, nibble: NIB_W'(i)};
            end
        end
        case (cg)
            CG_IDLE: v = '{invalid: 1'b0, control: 1'b1, nibble: NIB_IDLE};
            CG_SSD1, CG_SSD2:
                v = '{invalid: 1'b0, control: 1'b1, nibble: NIB_SSD};
            CG_ESD1, CG_ESD2:
                v = '{invalid: 1'b0, control: 1'b1, nibble: NIB_ESD};
            default: v = v;
        endcase
        return v;
    endfunction : cg_decode

endpackage : tx_coder_pkg

// ===== src/nib_if.sv
// nibble stream carrier between the buffer and the encoder
`timescale 1ns/1ps
interface nib_if #(parameter int W = 4);
    logic valid;
    logic ready;
    logic en;
    logic [W-1:0] data;
    modport src (output valid, output en, output data, input ready);
    modport snk (input valid, input en, input data, output ready);
endinterface : nib_if

// ===== src/nib_buffer.sv
// two-entry nibble buffer with valid and ready on both sides
`timescale 1ns/1ps
module nib_buffer #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // filling side
    input wire logic in_valid,
    input wire logic in_en,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // draining side
    nib_if.src q
);
    import tx_coder_pkg::*;

    // =========================================================
    // storage and pointers
    logic [W:0] mem_reg [BUF_DEPTH];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic ready_reg;
    wire push = in_valid & ready_reg;
    wire pop = q.valid & q.ready;

    // ready is registered so the source sees a clean level
    assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    assign in_ready = ready_reg;
    assign q.valid = (cnt_reg != 2'h0);
    assign q.en = mem_reg[rd_ptr_reg][W];
    assign q.data = mem_reg[rd_ptr_reg][W-1:0];

    // pointer and fill bookkeeping
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            cnt_reg <= 2'h0;
            ready_reg <= 1'b0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            cnt_reg <= cnt_next;
            ready_reg <= (cnt_next != 2'(BUF_DEPTH));
        end
    end

    // entries carry the enable flag beside the nibble
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= {in_en, in_data};
        end
    end

endmodule : nib_buffer

// ===== verif/mac_model.sv
// nibble source standing in for the mac
`timescale 1ns/1ps
module mac_model (
    // clock
    input wire logic ref_clk,
    // stream to the coder
    output logic nib_valid,
    output logic tx_enable,
    output logic [tx_coder_pkg::NIB_W-1:0] tx_nibble,
    input wire logic nib_ready
);
    initial
    begin
        nib_valid = 1'b0;
        tx_enable = 1'b0;
        tx_nibble = 4'h0;
    end

    // one word, held until taken at a ready edge
    task automatic put(input logic en, input logic [3:0] nib, input int gap);
        @(negedge ref_clk);
        nib_valid = 1'b1;
        tx_enable = en;
        tx_nibble = nib;
        do @(posedge ref_clk); while (nib_ready !== 1'b1);
        if (gap > 0)
            rest(gap);
    endtask : put

    // released lines show the inverse, never a stale word
    task automatic rest(input int n);
        @(negedge ref_clk);
        nib_valid = 1'b0;
        tx_enable = ~tx_enable;
        tx_nibble = ~tx_nibble;
        repeat (n - 1) @(negedge ref_clk);
    endtask : rest
endmodule : mac_model

// ===== verif/tx_symbol_encoder_asserts.sv
// port checks for the transmit coder
`timescale 1ns/1ps
module tx_symbol_encoder_asserts
    import tx_coder_pkg::*;
#(
    parameter int NW = tx_coder_pkg::NIB_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // stream and configuration
    input wire logic nib_valid,
    input wire logic tx_enable,
    input wire logic [NW-1:0] tx_nibble,
    input wire logic nib_ready,
    input wire logic [STRAP_W-1:0] phy_address_strap,
    input wire logic scramble_bypass,
    // line and status
    input wire logic line_drive_p,
    input wire logic line_drive_n,
    input wire logic frame_active,
    input wire logic [NW-1:0] sent_nibble,
    input wire logic sent_error
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    logic [3:0] up_reg;

    // cycles since reset; idle checks wait for the pipe to fill
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            up_reg <= 4'h0;
        else if (up_reg != 4'hF)
            up_reg <= up_reg + 4'h1;
    end

    // ==========
    // line, buffer and status properties

    property p_one_side;
        !(line_drive_p && line_drive_n);
    endproperty
    a_one_side: assert property (p_one_side)
        else $error("both drives high");
    property p_pos_step;
        line_drive_p |=> !line_drive_n;
    endproperty
    a_pos_step: assert property (p_pos_step)
        else $error("plus went straight to minus");
    property p_neg_step;
        line_drive_n |=> !line_drive_p;
    endproperty
    a_neg_step: assert property (p_neg_step)
        else $error("minus went straight to plus");
    property p_idle_toggle;
        (up_reg == 4'hF && scramble_bypass && !frame_active)[*8] |->
            (line_drive_p != $past(line_drive_p)) ||
            (line_drive_n != $past(line_drive_n));
    endproperty
    a_idle_toggle: assert property (p_idle_toggle)
        else $error("plain idle did not step the line");
    property p_drain;
        // the closing R group pops nothing, so one extra group may pass
        $fell(nib_ready) |-> ##[1:9] nib_ready;
    endproperty
    a_drain: assert property (p_drain)
        else $error("buffer not drained in a group time");
    property p_quiet_nib;
        !frame_active |-> sent_nibble == NIB_IDLE && !sent_error;
    endproperty
    a_quiet_nib: assert property (p_quiet_nib)
        else $error("idle group not read as zero");
    property p_start_nib;
        $rose(frame_active) |-> sent_nibble == NIB_SSD && !sent_error;
    endproperty
    a_start_nib: assert property (p_start_nib)
        else $error("frame did not open with a start group");
    property p_frame_len;
        $rose(frame_active) |-> frame_active[*8];
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame shorter than its delimiters");
    property p_err_nib;
        sent_error |-> sent_nibble == NIB_BAD;
    endproperty
    a_err_nib: assert property (p_err_nib)
        else $error("error group not read as E");
endmodule : tx_symbol_encoder_asserts

bind tx_symbol_encoder tx_symbol_encoder_asserts #(.NW(NW)) i_chk (
    .ref_clk(ref_clk), .nrst(nrst), .nib_valid(nib_valid),
    .tx_enable(tx_enable), .tx_nibble(tx_nibble), .nib_ready(nib_ready),
    .phy_address_strap(phy_address_strap),
    .scramble_bypass(scramble_bypass), .line_drive_p(line_drive_p),
    .line_drive_n(line_drive_n), .frame_active(frame_active),
    .sent_nibble(sent_nibble), .sent_error(sent_error));

// ===== verif/tx_symbol_encoder_test.sv
// self-checking bench for the transmit coder
`timescale 1ns/1ps
module tx_symbol_encoder_test;
    import tx_coder_pkg::*;
    logic ref_clk;
    logic nrst;
    logic nib_valid;
    logic tx_enable;
    logic [NIB_W-1:0] tx_nibble;
    logic nib_ready;
    logic [STRAP_W-1:0] phy_address_strap;
    logic scramble_bypass;
    logic line_drive_p;
    logic line_drive_n;
    logic frame_active;
    logic [NIB_W-1:0] sent_nibble;
    logic sent_error;
    int errors;
    int n_compared;
    logic [CG_W-1:0] got[$];
    logic [CG_W-1:0] exp_q[$];
    logic [1:0] ph_reg;
    logic [10:0] hist_reg;
    logic [9:0] sh_reg;
    int lock_cnt;
    int bit_cnt;
    logic aligned;
    logic full_seen;
    logic err_seen;

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    tx_symbol_encoder i_dut (.ref_clk(ref_clk), .nrst(nrst),
        .nib_valid(nib_valid), .tx_enable(tx_enable), .tx_nibble(tx_nibble),
        .nib_ready(nib_ready), .phy_address_strap(phy_address_strap),
        .scramble_bypass(scramble_bypass), .line_drive_p(line_drive_p),
        .line_drive_n(line_drive_n), .frame_active(frame_active),
        .sent_nibble(sent_nibble), .sent_error(sent_error));
    mac_model i_mac (.ref_clk(ref_clk), .nib_valid(nib_valid),
        .tx_enable(tx_enable), .tx_nibble(tx_nibble), .nib_ready(nib_ready));

    // ==========
    // line monitor: undo three-level and nrzi, descramble, cut groups
    always @(posedge ref_clk or negedge nrst)
    begin : mon
        logic tog;
        logic nb;
        logic b;
        if (!nrst)
        begin
            ph_reg <= 2'h0;
            lock_cnt <= 0;
            aligned <= 1'b0;
            full_seen <= 1'b0;
            err_seen <= 1'b0;
        end
        else
        begin
            tog = ({line_drive_n, line_drive_p} != ph_reg);
            // learn the sequence from idle, then predict it
            nb = (lock_cnt < 20) ? ~tog : hist_reg[10] ^ hist_reg[8];
            b = scramble_bypass ? tog : tog ^ nb;
            ph_reg <= {line_drive_n, line_drive_p};
            hist_reg <= {hist_reg[9:0], nb};
            lock_cnt <= scramble_bypass ? 0 : lock_cnt + 1;
            sh_reg <= {sh_reg[8:0], b};
            full_seen <= full_seen | (nib_valid & ~nib_ready);
            err_seen <= err_seen | sent_error;
            if (!aligned && {sh_reg[8:0], b} == 10'h3F8)
            begin
                aligned <= 1'b1;
                bit_cnt <= 0;
                got.push_back(CG_SSD1);
            end
            else if (aligned && bit_cnt == 4)
            begin
                got.push_back({sh_reg[3:0], b});
                aligned <= ({sh_reg[3:0], b} != CG_IDLE);
                bit_cnt <= 0;
            end
            else
                bit_cnt <= bit_cnt + 1;
        end
    end

    // ==========
    // shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want)
        begin
            errors++;
            $display("FAIL %0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic do_reset(input logic [4:0] strap);
        @(negedge ref_clk);
        nrst = 1'b0;
        phy_address_strap = strap;
        repeat (4) @(negedge ref_clk);
        nrst = 1'b1;
    endtask : do_reset

    task automatic set_mode(input logic byp, input int settle);
        @(negedge ref_clk);
        scramble_bypass = byp;
        repeat (settle) @(negedge ref_clk);
    endtask : set_mode

    // two preamble octets, all sixteen nibbles, then the closing word
    task automatic send_frame(input int gap_at, input int gap);
        exp_q = '{CG_SSD1, CG_SSD2, DATA_CG[5], DATA_CG[5]};
        got.delete();
        for (int i = 0; i < 20; i++)
            i_mac.put(1'b1, (i < 4) ? 4'h5 : 4'(i - 4), (i == gap_at) ? gap : 0);
        i_mac.put(1'b0, 4'hA, 0);
        i_mac.rest(1);
        for (int i = 0; i < 16; i++)
            exp_q.push_back(DATA_CG[i]);
        exp_q.push_back(CG_ESD1);
        exp_q.push_back(CG_ESD2);
        for (int k = 0; k < 400 && !(got.size() > 0 && got[$] === CG_IDLE); k++)
            @(posedge ref_clk);
    endtask : send_frame

    task automatic judge(input logic strip);
        logic [CG_W-1:0] g[$];
        foreach (got[i])
            if (!strip || got[i] !== CG_HALT)
                g.push_back(got[i]);
        check(8'(g.size()), 8'(exp_q.size() + 1));
        foreach (exp_q[i])
            check(8'(g[i]), 8'(exp_q[i]));
        check(8'(g[$]), 8'(CG_IDLE));
    endtask : judge

    // ==========
    // scenarios
    task automatic t_plain();
        set_mode(1'b1, 40);
        send_frame(-1, 0);
        judge(1'b0);
        check(8'(full_seen), 8'h01);
        check(8'(err_seen), 8'h00);
        $display("test plain done");
    endtask : t_plain

    task automatic t_scrambled();
        set_mode(1'b0, 60);
        check(8'(hist_reg != 11'h000), 8'h01);
        send_frame(-1, 0);
        judge(1'b0);
        check(8'(err_seen), 8'h00);
        $display("test scrambled done");
    endtask : t_scrambled

    task automatic t_underrun();
        set_mode(1'b1, 40);
        send_frame(8, 20);
        judge(1'b1);
        check(8'(got.size() > exp_q.size() + 1), 8'h01);
        check(8'(err_seen), 8'h01);
        $display("test underrun done");
    endtask : t_underrun

    task automatic capture(output logic [63:0] t);
        t = 64'h0;
        repeat (40) @(negedge ref_clk);
        repeat (32)
        begin
            @(negedge ref_clk);
            t = {t[61:0], line_drive_n, line_drive_p};
        end
    endtask : capture

    // two straps must start the scrambler from two states
    task automatic t_seed();
        logic [63:0] ta;
        logic [63:0] tb;
        set_mode(1'b0, 1);
        do_reset(5'h03);
        capture(ta);
        do_reset(5'h1C);
        capture(tb);
        check(8'(ta !== tb), 8'h01);
        $display("test seed done");
    endtask : t_seed

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    // hang guard, far beyond the under one thousand cycles the tests need
    initial
    begin
        #100000;
        errors++;
        wrap_up();
    end

    initial
    begin
        errors = 0;
        n_compared = 0;
        nrst = 1'b0;
        scramble_bypass = 1'b1;
        phy_address_strap = 5'h01;
        repeat (4) @(negedge ref_clk);
        nrst = 1'b1;
        t_plain();
        t_scrambled();
        t_underrun();
        t_seed();
        wrap_up();
    end
endmodule : tx_symbol_encoder_test
